/* ast_uart_tx.sv */
// Asynchronous serial transmitter with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`default_nettype none

module ast_uart_tx
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep,
  output logic tx_out,
  output logic tx_oe_n,
  output logic tx_irq
);
  import ast_pkg::*;

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [11:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg, aw_full_reg, w_full_reg;
  logic serial_port_enable_reg, nine_bit_select_reg, transmit_enable_reg;
  logic sync_sel_reg, high_speed_sel_reg, ninth_tx_bit_reg, tx_buf_irq_enable_reg;
  logic [7:0] baud_divisor_reg, tx_holding_buf_reg;
  logic tx_buf_empty_flag_reg, buf_full_reg;
  ast_tx_state_t state_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [5:0] tick_cnt_reg;
  logic tx_out_reg, tx_oe_n_reg, tx_irq_reg;
  logic wr_fire, wr_lane, aw_hs, w_hs, ar_hs, addr_ok_w, addr_ok_r;
  logic hold_wr, txcs_wr, enable_rise, active, run_ok, baud_run, tick;
  logic bit_end, last_data, stop_done, load, shifter_empty;
  logic [5:0] ticks_last;
  logic [7:0] rd_byte;

  // Bus handshakes; write address and data may arrive in either order
  assign aw_hs = s_axi_awvalid && awready_reg;
  assign w_hs = s_axi_wvalid && wready_reg;
  assign ar_hs = s_axi_arvalid && arready_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign addr_ok_w = aw_addr_reg == ADDR_IRQ_FLAGS || aw_addr_reg == ADDR_RX_CS ||
    aw_addr_reg == ADDR_TX_HOLD || aw_addr_reg == ADDR_IRQ_EN ||
    aw_addr_reg == ADDR_TX_CS || aw_addr_reg == ADDR_DIVISOR;
  assign wr_lane = wr_fire && w_lane_reg && addr_ok_w;
  assign hold_wr = wr_lane && aw_addr_reg == ADDR_TX_HOLD;
  assign txcs_wr = wr_lane && aw_addr_reg == ADDR_TX_CS;
  assign enable_rise = txcs_wr && w_data_reg[TXCS_TX_EN_BIT] && !transmit_enable_reg;

  // Transmitter runs only in asynchronous mode with port and transmitter on
  assign active = serial_port_enable_reg && transmit_enable_reg && !sync_sel_reg;
  assign run_ok = active && !sleep;
  assign baud_run = run_ok && state_reg != TX_IDLE;
  assign ticks_last = high_speed_sel_reg ? TICKS_LAST_X16 : TICKS_LAST_X64;
  assign bit_end = tick && !sleep && tick_cnt_reg == ticks_last; // A tick landing as sleep starts is dropped
  assign last_data = bit_cnt_reg == (nine_bit_select_reg ? LAST_BIT_9 : LAST_BIT_8);
  assign stop_done = state_reg == TX_STOP && bit_end;
  // A write to the buffer defers the transfer one cycle, so flag never races
  assign load = run_ok && buf_full_reg && !hold_wr && (state_reg == TX_IDLE || stop_done);
  assign shifter_empty = state_reg == TX_IDLE;

  ast_baud_gen ast_baud_gen_inst
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(baud_run),
    .baud_divisor(baud_divisor_reg),
    .tick(tick)
  );

  // Write address and data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= BYTE_RESET;
      w_lane_reg <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_full_reg <= 1'b0;
      if (w_hs)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0]; // Only the low lane holds data
      end
      else if (wr_fire)
        w_full_reg <= 1'b0;
    end
  end

  // Write ready and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      awready_reg <= !(aw_full_reg || aw_hs) && !bvalid_reg && !wr_fire;
      wready_reg <= !(w_full_reg || w_hs) && !bvalid_reg && !wr_fire;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_port_enable_reg <= 1'b0;
      nine_bit_select_reg <= 1'b0;
      transmit_enable_reg <= 1'b0;
      sync_sel_reg <= 1'b0;
      high_speed_sel_reg <= 1'b0;
      ninth_tx_bit_reg <= 1'b0;
      tx_buf_irq_enable_reg <= 1'b0;
      baud_divisor_reg <= BYTE_RESET;
    end
    else if (wr_lane)
    begin
      case (aw_addr_reg)
        ADDR_RX_CS: serial_port_enable_reg <= w_data_reg[RXCS_PORT_EN_BIT];
        ADDR_IRQ_EN: tx_buf_irq_enable_reg <= w_data_reg[IRQ_EN_BUF_BIT];
        ADDR_DIVISOR: baud_divisor_reg <= w_data_reg;
        ADDR_TX_CS:
        begin
          nine_bit_select_reg <= w_data_reg[TXCS_NINE_BIT];
          transmit_enable_reg <= w_data_reg[TXCS_TX_EN_BIT];
          sync_sel_reg <= w_data_reg[TXCS_SYNC_BIT];
          high_speed_sel_reg <= w_data_reg[TXCS_HIGH_SPEED_BIT];
          ninth_tx_bit_reg <= w_data_reg[TXCS_NINTH_BIT];
        end
        default: ;
      endcase
    end
  end

  // Holding buffer and its empty flag; the flag register ignores bus writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_holding_buf_reg <= BYTE_RESET;
      buf_full_reg <= 1'b0;
      tx_buf_empty_flag_reg <= 1'b0;
    end
    else
    begin
      if (hold_wr)
      begin
        tx_holding_buf_reg <= w_data_reg;
        buf_full_reg <= 1'b1;
      end
      else if (load || !transmit_enable_reg)
        buf_full_reg <= 1'b0; // Disabling drops a pending character
      if (load || enable_rise)
        tx_buf_empty_flag_reg <= 1'b1;
      else if (hold_wr)
        tx_buf_empty_flag_reg <= 1'b0;
    end
  end

  // Frame sequencer; sleep freezes it in place, disabling aborts it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !active)
      state_reg <= TX_IDLE;
    else if (!sleep)
    begin
      case (state_reg)
        TX_IDLE: if (load) state_reg <= TX_START;
        TX_START: if (bit_end) state_reg <= TX_DATA;
        TX_DATA: if (bit_end && last_data) state_reg <= TX_STOP;
        TX_STOP: if (bit_end) state_reg <= load ? TX_START : TX_IDLE;
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

  // Shifter and bit counter; only the sequencer reaches the shifter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_shift_reg <= 9'h000;
      bit_cnt_reg <= 4'h0;
    end
    else if (load)
    begin
      tx_shift_reg <= {ninth_tx_bit_reg & nine_bit_select_reg, tx_holding_buf_reg};
      bit_cnt_reg <= 4'h0;
    end
    else if (run_ok && state_reg == TX_DATA && bit_end)
    begin
      tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Oversampling tick counter within one bit period
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !active || state_reg == TX_IDLE)
      tick_cnt_reg <= 6'h00;
    else if (bit_end)
      tick_cnt_reg <= 6'h00;
    else if (tick && !sleep)
      tick_cnt_reg <= tick_cnt_reg + 6'h01;
  end

  // Line and pin drivers; idle line is high while the port owns the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_out_reg <= 1'b1;
      tx_oe_n_reg <= 1'b1;
      tx_irq_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        TX_START: tx_out_reg <= 1'b0;
        TX_DATA: tx_out_reg <= tx_shift_reg[0];
        default: tx_out_reg <= 1'b1;
      endcase
      tx_oe_n_reg <= !serial_port_enable_reg;
      tx_irq_reg <= tx_buf_empty_flag_reg && tx_buf_irq_enable_reg;
    end
  end

  // Read data select; unused bits read zero
  always_comb
  begin
    rd_byte = BYTE_RESET;
    addr_ok_r = 1'b1;
    case (s_axi_araddr)
      ADDR_IRQ_FLAGS: rd_byte[FLAG_BUF_EMPTY_BIT] = tx_buf_empty_flag_reg;
      ADDR_RX_CS: rd_byte[RXCS_PORT_EN_BIT] = serial_port_enable_reg;
      ADDR_TX_HOLD: rd_byte = tx_holding_buf_reg;
      ADDR_IRQ_EN: rd_byte[IRQ_EN_BUF_BIT] = tx_buf_irq_enable_reg;
      ADDR_TX_CS:
      begin
        rd_byte[TXCS_NINE_BIT] = nine_bit_select_reg;
        rd_byte[TXCS_TX_EN_BIT] = transmit_enable_reg;
        rd_byte[TXCS_SYNC_BIT] = sync_sel_reg;
        rd_byte[TXCS_HIGH_SPEED_BIT] = high_speed_sel_reg;
        rd_byte[TXCS_SHIFTER_EMPTY_BIT] = shifter_empty;
        rd_byte[TXCS_NINTH_BIT] = ninth_tx_bit_reg;
      end
      ADDR_DIVISOR: rd_byte = baud_divisor_reg;
      default: addr_ok_r = 1'b0;
    endcase
  end

  // Read channel; one read outstanding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      arready_reg <= !rvalid_reg && !ar_hs;
      if (ar_hs)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= addr_ok_r ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign tx_out = tx_out_reg;
  assign tx_oe_n = tx_oe_n_reg;
  assign tx_irq = tx_irq_reg;

  a_load_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    load |=> tx_buf_empty_flag_reg && !buf_full_reg && state_reg == TX_START)
    else $error("transfer did not empty buffer and set flag");

  a_write_clears_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (hold_wr && !enable_rise) |=> !tx_buf_empty_flag_reg && buf_full_reg)
    else $error("buffer write did not clear flag");

  a_flag_not_soft: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_lane && aw_addr_reg == ADDR_IRQ_FLAGS && !load) |=> $stable(tx_buf_empty_flag_reg))
    else $error("software write changed buffer empty flag");

  a_enable_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_rise |=> tx_buf_empty_flag_reg && transmit_enable_reg)
    else $error("transmit enable did not set flag");

  a_load_when_free: assert property (@(posedge aclk) disable iff (!aresetn)
    (load && state_reg != TX_IDLE) |-> state_reg == TX_STOP && bit_end)
    else $error("shifter loaded before stop bit finished");

  a_sleep_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep && active && $past(sleep)) |=> $stable(state_reg) && $stable(tx_shift_reg))
    else $error("transmitter moved during sleep");

  a_start_bit_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == TX_START) |=> !tx_out)
    else $error("start bit not low");

  a_stop_bit_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == TX_DATA ##1 state_reg == TX_STOP) |=> tx_out)
    else $error("stop bit not high");

  a_pin_handover: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_port_enable_reg |=> !tx_oe_n)
    else $error("pin not driven with port enabled");

  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_buf_empty_flag_reg && !tx_buf_irq_enable_reg) |=> !tx_irq)
    else $error("interrupt raised while disabled");

  a_empty_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == ADDR_TX_CS) |=> s_axi_rdata[1] == $past(state_reg == TX_IDLE))
    else $error("shifter empty status wrong");
endmodule

`default_nettype wire

/* ast_baud_gen.sv */
// Shared constants package and the down-counting baud tick generator
`default_nettype none

package ast_pkg;
  // Register indices; a byte address is four times its index
  localparam logic [11:0] IDX_IRQ_FLAGS = 12'h00C;
  localparam logic [11:0] IDX_RX_CS = 12'h018;
  localparam logic [11:0] IDX_TX_HOLD = 12'h019;
  localparam logic [11:0] IDX_IRQ_EN = 12'h08C;
  localparam logic [11:0] IDX_TX_CS = 12'h098;
  localparam logic [11:0] IDX_DIVISOR = 12'h099;
  localparam logic [11:0] ADDR_IRQ_FLAGS = 12'(IDX_IRQ_FLAGS * 4);
  localparam logic [11:0] ADDR_RX_CS = 12'(IDX_RX_CS * 4);
  localparam logic [11:0] ADDR_TX_HOLD = 12'(IDX_TX_HOLD * 4);
  localparam logic [11:0] ADDR_IRQ_EN = 12'(IDX_IRQ_EN * 4);
  localparam logic [11:0] ADDR_TX_CS = 12'(IDX_TX_CS * 4);
  localparam logic [11:0] ADDR_DIVISOR = 12'(IDX_DIVISOR * 4);
  // Field positions
  localparam int FLAG_BUF_EMPTY_BIT = 4;
  localparam int IRQ_EN_BUF_BIT = 4;
  localparam int RXCS_PORT_EN_BIT = 7;
  localparam int TXCS_NINE_BIT = 6;
  localparam int TXCS_TX_EN_BIT = 5;
  localparam int TXCS_SYNC_BIT = 4;
  localparam int TXCS_HIGH_SPEED_BIT = 2;
  localparam int TXCS_SHIFTER_EMPTY_BIT = 1;
  localparam int TXCS_NINTH_BIT = 0;
  // Reset values
  localparam logic [7:0] TXCS_RESET = 8'h02;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Ticks per bit minus one, for x16 and x64 oversampling
  localparam logic [5:0] TICKS_LAST_X16 = 6'h0F;
  localparam logic [5:0] TICKS_LAST_X64 = 6'h3F;
  // Data bit index of the last bit for 8 and 9 bit frames
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } ast_tx_state_t;
endpackage

module ast_baud_gen
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [7:0] baud_divisor,
  output logic tick
);
  import ast_pkg::*;

  logic [7:0] count_reg;
  logic tick_reg;

  // Reload whenever stopped so each frame starts a full period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= BYTE_RESET;
      tick_reg <= 1'b0;
    end
    else if (!run)
    begin
      count_reg <= baud_divisor;
      tick_reg <= 1'b0;
    end
    else if (count_reg == BYTE_RESET)
    begin
      count_reg <= baud_divisor;
      tick_reg <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg - 8'h01;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;

  a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && run && baud_divisor != 8'h00 && count_reg == baud_divisor) |=> !tick)
    else $error("baud tick repeated before divisor expired");
endmodule

`default_nettype wire

/* ast_rx_model.sv */
// Remote asynchronous receiver model that decodes frames from the serial line
`default_nettype none

module ast_rx_model
(
  input wire logic aclk,
  input wire logic line,
  input wire logic hold,
  input wire logic nine,
  input wire logic [15:0] bit_cycles,
  output logic got,
  output logic [8:0] data,
  output logic stop_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;

  // Counts only cycles outside the stall, so a frozen bit is not cut short
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (k < n)
    begin
      @(posedge aclk);
      if (!hold)
        k++;
    end
  endtask

  // Low line starts a frame; every later bit is sampled at its middle
  always
  begin
    @(posedge aclk);
    got <= 1'b0;
    if (!line && !hold)
    begin
      wait_bits(int'(bit_cycles) / 2);
      if (!line)
      begin
        data <= 9'h000;
        for (i = 0; i < (nine ? 9 : 8); i++)
        begin
          wait_bits(int'(bit_cycles));
          data[i] <= line;
        end
        wait_bits(int'(bit_cycles));
        stop_ok <= line;
        got <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

/* ast_uart_tx_tb.sv */
// Self-checking testbench for the asynchronous serial transmitter
`default_nettype none

module ast_uart_tx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ast_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, sleep = 1'b0, rx_nine = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_out, tx_oe_n, tx_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] bit_cyc = 16'h0010;
  logic rx_got, rx_stop;
  logic [8:0] rx_data;
  wire logic tx_line;
  logic [31:0] rd_exp[$], rd_mask[$];
  logic [9:0] fr_q[$];
  logic [1:0] rr_q[$];
  int n_fail = 0, n_compared = 0, seed = 39769;

  // Released pin floats to the pull-up level
  assign tx_line = tx_oe_n ? 1'b1 : tx_out;

  ast_uart_tx ast_uart_tx_inst
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep, .tx_out, .tx_oe_n, .tx_irq
  );

  ast_rx_model ast_rx_model_inst
  (
    .aclk, .line(tx_line), .hold(sleep), .nine(rx_nine), .bit_cycles(bit_cyc), .got(rx_got),
    .data(rx_data), .stop_ok(rx_stop)
  );

  always #2 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic hang(input string what);
    chk(what, 32'h00000000, 32'h00000001);
    print_verdict();
  endtask

  // Address and data offered together; the spacing after B keeps the slave's order
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp = RESP_OKAY);
    int k;
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100 && !done; k++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
      end
    end
    if (!done)
      hang("write response");
    repeat (2) @(posedge aclk);
  endtask

  // Read data is judged by the monitor against the note left here
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
    input logic [1:0] rs = RESP_OKAY);
    int k;
    logic done;
    done = 1'b0;
    rd_exp.push_back(e);
    rd_mask.push_back(m);
    rr_q.push_back(rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100 && !done; k++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    if (!done)
      hang("read response");
    repeat (2) @(posedge aclk);
  endtask

  task automatic send(input logic ninth);
    logic [7:0] b;
    b = 8'($random(seed));
    fr_q.push_back({1'b1, ninth & rx_nine, b});
    wr(ADDR_TX_HOLD, b);
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 20000 && fr_q.size() > 0; k++)
      @(posedge aclk);
    if (fr_q.size() > 0)
      hang("frame wait");
    // The model reports mid-stop, so let the stop bit finish
    repeat (bit_cyc) @(posedge aclk);
  endtask

  // Oldest note is taken whenever a read answer or a received frame appears
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && rd_exp.size() > 0)
    begin
      chk("rdata", rd_exp.pop_front(), s_axi_rdata & rd_mask.pop_front());
      chk("rresp", {30'h0, rr_q.pop_front()}, {30'h0, s_axi_rresp});
    end
    if (rx_got === 1'b1)
    begin
      if (fr_q.size() == 0)
        hang("unexpected frame");
      else
        chk("frame", {22'h0, fr_q.pop_front()}, {22'h0, rx_stop, rx_data});
    end
  end

  initial
  begin
    logic [11:0] zr [6];
    int i;
    logic b0, st;
    zr = '{ADDR_IRQ_FLAGS, ADDR_RX_CS, ADDR_TX_HOLD, ADDR_IRQ_EN, ADDR_DIVISOR, 12'h004};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("tx_out", 32'h1, {31'h0, tx_out});
    chk("tx_oe_n", 32'h1, {31'h0, tx_oe_n});
    rd(ADDR_TX_CS, 32'h00000002);
    for (i = 0; i < 6; i++)
      rd(zr[i], 32'h00000000, 32'hFFFFFFFF, (i == 5) ? RESP_SLVERR : RESP_OKAY);
    wr(12'h004, 8'h5A, RESP_SLVERR);
    // Low byte lane off: the write is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    wr(ADDR_DIVISOR, 8'h33);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_DIVISOR, 32'h00000000);
    wr(ADDR_TX_CS, 8'h00);
    rd(ADDR_TX_CS, 32'h00000002);
    $display("reset test done");
    // Software setup order: divisor, speed, async, port enable
    wr(ADDR_DIVISOR, 8'h00);
    wr(ADDR_TX_CS, 8'h04);
    wr(ADDR_RX_CS, 8'h80);
    chk("tx_oe_n", 32'h0, {31'h0, tx_oe_n});
    rd(ADDR_IRQ_FLAGS, 32'h0);
    wr(ADDR_IRQ_EN, 8'h10);
    wr(ADDR_TX_CS, 8'h24);
    rd(ADDR_IRQ_FLAGS, 32'h10);
    chk("tx_irq", 32'h1, {31'h0, tx_irq});
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_IRQ_FLAGS, 32'h10);
    chk("tx_irq", 32'h0, {31'h0, tx_irq});
    wr(ADDR_IRQ_EN, 8'h10);
    $display("setup test done");
    // Second byte waits in the buffer behind the first frame
    send(1'b0);
    rd(ADDR_IRQ_FLAGS, 32'h10);
    send(1'b0);
    rd(ADDR_IRQ_FLAGS, 32'h0);
    rd(ADDR_TX_CS, 32'h0, 32'h2);
    chk("tx_irq", 32'h0, {31'h0, tx_irq});
    drain();
    rd(ADDR_TX_CS, 32'h2, 32'h2);
    rd(ADDR_IRQ_FLAGS, 32'h10);
    $display("back to back test done");
    rx_nine <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      wr(ADDR_TX_CS, 8'h64 | 8'(i));
      send(1'(i));
      drain();
    end
    rx_nine <= 1'b0;
    $display("nine bit test done");
    // Slow x64 rate, then x16 with a larger divisor
    for (i = 1; i < 3; i++)
    begin
      wr(ADDR_DIVISOR, 8'(i));
      wr(ADDR_TX_CS, (i == 2) ? 8'h24 : 8'h20);
      bit_cyc <= (i == 2) ? 16'h0030 : 16'h0080;
      send(1'b0);
      drain();
    end
    $display("rate test done");
    send(1'b0);
    repeat (100) @(posedge aclk);
    sleep <= 1'b1;
    repeat (2) @(posedge aclk);
    b0 = tx_out;
    st = 1'b1;
    repeat (150)
    begin
      @(posedge aclk);
      if (tx_out !== b0)
        st = 1'b0;
    end
    chk("sleep hold", 32'h1, {31'h0, st});
    sleep <= 1'b0;
    drain();
    $display("sleep test done");
    // Synchronous select set: a loaded byte must not leave as an async frame
    wr(ADDR_TX_CS, 8'h34);
    wr(ADDR_TX_HOLD, 8'hA5);
    st = 1'b1;
    repeat (600)
    begin
      @(posedge aclk);
      if (tx_out !== 1'b1)
        st = 1'b0;
    end
    chk("sync line", 32'h1, {31'h0, st});
    rd(ADDR_TX_CS, 32'h2, 32'h2);
    $display("sync test done");
    print_verdict();
  end
endmodule

`default_nettype wire
